/* File: logic/ovf_flags.sv */
// Overrange detection top: thresholds, flag pins, tagged samples, events.
// Assumes samples are two's complement and synchronous to clk, one per cycle.
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps

module ovf_flags (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ovf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [ovf_pkg::SAMPLE_W-1:0] chan_a_sample,
    input wire logic [ovf_pkg::SAMPLE_W-1:0] chan_b_sample,
    input wire logic serial_link_enable,
    output ovf_pkg::ovf_sample_s chan_a_data_out,
    output ovf_pkg::ovf_sample_s chan_b_data_out,
    output logic chan_a_flag_zero,
    output logic chan_a_flag_one,
    output logic chan_b_flag_zero,
    output logic chan_b_flag_one,
    output logic irq
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [ovf_pkg::LIMIT_W-1:0] first_level_limit;
    logic [ovf_pkg::LIMIT_W-1:0] second_level_limit;
    logic [7:0] flag_config_register;
    logic [ovf_pkg::EV_W-1:0] event_status;
    logic [ovf_pkg::EV_W-1:0] event_mask;
    ovf_pkg::ovf_cfg_s cfg;

    assign cfg.pin_enable = flag_config_register[ovf_pkg::CFG_PIN_EN_BIT];
    assign cfg.exponent = flag_config_register[ovf_pkg::CFG_EXP_LSB +: ovf_pkg::CFG_EXP_W];

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic [ovf_pkg::IDX_W-1:0] reg_index;
    logic lane_ok;
    logic sel_first;
    logic sel_second;
    logic sel_config;
    logic sel_status;
    logic sel_mask;

    assign reg_index = reg_addr[ovf_pkg::ADDR_W-1:2];
    assign lane_ok = (reg_addr[1:0] == ovf_pkg::ADDR_LANE);
    assign sel_first = lane_ok && (reg_index == ovf_pkg::IDX_FIRST_LEVEL_LIMIT);
    assign sel_second = lane_ok && (reg_index == ovf_pkg::IDX_SECOND_LEVEL_LIMIT);
    assign sel_config = lane_ok && (reg_index == ovf_pkg::IDX_FLAG_CONFIG);
    assign sel_status = lane_ok && (reg_index == ovf_pkg::IDX_EVENT_STATUS);
    assign sel_mask = lane_ok && (reg_index == ovf_pkg::IDX_EVENT_MASK);

    // ****************************************************************
    // Level limits
    // ****************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            first_level_limit <= ovf_pkg::RST_FIRST_LEVEL_LIMIT;
            second_level_limit <= ovf_pkg::RST_SECOND_LEVEL_LIMIT;
        end
        else if (reg_write)
        begin
            if (sel_first)
            begin
                first_level_limit <= reg_wdata;
            end
            if (sel_second)
            begin
                second_level_limit <= reg_wdata;
            end
        end
    end

    // ****************************************************************
    // Configuration: pin enable and stretch exponent
    // ****************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            flag_config_register <= ovf_pkg::RST_FLAG_CONFIG;
        end
        else if (reg_write && sel_config)
        begin
            flag_config_register <= reg_wdata;
        end
    end

    // ****************************************************************
    // Magnitude on the 256 full-scale scale
    // ****************************************************************
    function automatic logic [ovf_pkg::MAG_W-1:0] scaled_mag(input logic [ovf_pkg::SAMPLE_W-1:0] s);
        logic [ovf_pkg::SAMPLE_W-1:0] neg;
        logic [ovf_pkg::MAG_W-1:0] mag;
        begin
            neg = ~s + 8'h01;
            if (s[ovf_pkg::SAMPLE_W-1])
            begin
                mag = {neg == 8'h80, neg[ovf_pkg::SAMPLE_W-2:0], 1'b0};
            end
            else
            begin
                mag = {1'b0, s[ovf_pkg::SAMPLE_W-2:0], 1'b0};
            end
            scaled_mag = mag;
        end
    endfunction

    logic [ovf_pkg::MAG_W-1:0] mag_a;
    logic [ovf_pkg::MAG_W-1:0] mag_b;
    logic [1:0] hit_a;
    logic [1:0] hit_b;

    assign mag_a = scaled_mag(chan_a_sample);
    assign mag_b = scaled_mag(chan_b_sample);
    assign hit_a[0] = mag_a >= {1'b0, first_level_limit};
    assign hit_a[1] = mag_a >= {1'b0, second_level_limit};
    assign hit_b[0] = mag_b >= {1'b0, first_level_limit};
    assign hit_b[1] = mag_b >= {1'b0, second_level_limit};

    // ****************************************************************
    // Tagged output samples, independent of the pin enable
    // ****************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            chan_a_data_out <= '0;
            chan_b_data_out <= '0;
        end
        else
        begin
            chan_a_data_out.sample <= chan_a_sample;
            chan_a_data_out.over <= hit_a;
            chan_b_data_out.sample <= chan_b_sample;
            chan_b_data_out.over <= hit_b;
        end
    end

    // ****************************************************************
    // Monitoring period counter
    // ****************************************************************
    logic [ovf_pkg::PERIOD_W-1:0] period_cnt;
    logic [ovf_pkg::PERIOD_W-1:0] period_last;
    logic [ovf_pkg::CFG_EXP_W-1:0] exp_seen;
    logic period_end;
    logic exp_changed;

    assign period_last = (ovf_pkg::PERIOD_BASE << cfg.exponent) - ovf_pkg::PERIOD_ONE;
    assign period_end = (period_cnt >= period_last);
    assign exp_changed = (exp_seen != cfg.exponent);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            exp_seen <= ovf_pkg::RST_FLAG_CONFIG[ovf_pkg::CFG_EXP_LSB +: ovf_pkg::CFG_EXP_W];
        end
        else
        begin
            exp_seen <= cfg.exponent;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            period_cnt <= '0;
        end
        else if (exp_changed && !serial_link_enable)
        begin
            // Restart in phase only while the link is down
            period_cnt <= '0;
        end
        else if (period_end)
        begin
            period_cnt <= '0;
        end
        else
        begin
            period_cnt <= period_cnt + ovf_pkg::PERIOD_ONE;
        end
    end

    // ****************************************************************
    // Flag pin stretchers, one per channel
    // ****************************************************************
    logic [1:0] pins_a;
    logic [1:0] pins_b;

    ovf_stretch #(
        .FLAGS(2)
    ) u_stretch_a (
        .clk(clk),
        .reset(reset),
        .period_end(period_end),
        .pin_enable(cfg.pin_enable),
        .hit(hit_a),
        .flag(pins_a)
    );

    ovf_stretch #(
        .FLAGS(2)
    ) u_stretch_b (
        .clk(clk),
        .reset(reset),
        .period_end(period_end),
        .pin_enable(cfg.pin_enable),
        .hit(hit_b),
        .flag(pins_b)
    );

    assign chan_a_flag_zero = pins_a[0];
    assign chan_a_flag_one = pins_a[1];
    assign chan_b_flag_zero = pins_b[0];
    assign chan_b_flag_one = pins_b[1];

    // ****************************************************************
    // Sticky events, write one to clear, set wins
    // ****************************************************************
    logic [ovf_pkg::EV_W-1:0] ev_set;
    logic [ovf_pkg::EV_W-1:0] ev_clear;
    logic [ovf_pkg::EV_W-1:0] next_event_status;

    assign ev_set = {hit_b[1], hit_b[0], hit_a[1], hit_a[0]};
    assign ev_clear = (reg_write && sel_status) ? reg_wdata[ovf_pkg::EV_W-1:0] : '0;
    assign next_event_status = (event_status & ~ev_clear) | ev_set;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            event_status <= ovf_pkg::RST_EVENT_STATUS;
        end
        else
        begin
            event_status <= next_event_status;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            event_mask <= ovf_pkg::RST_EVENT_MASK;
        end
        else if (reg_write && sel_mask)
        begin
            event_mask <= reg_wdata[ovf_pkg::EV_W-1:0];
        end
    end

    logic [ovf_pkg::EV_W-1:0] next_mask;

    assign next_mask = (reg_write && sel_mask) ? reg_wdata[ovf_pkg::EV_W-1:0] : event_mask;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(next_event_status & next_mask);
        end
    end

    // ****************************************************************
    // Read port, data one cycle after the strobe
    // ****************************************************************
    logic [7:0] next_rdata;

    always_comb
    begin
        next_rdata = 8'h00;
        if (sel_first)
        begin
            next_rdata = first_level_limit;
        end
        else if (sel_second)
        begin
            next_rdata = second_level_limit;
        end
        else if (sel_config)
        begin
            next_rdata = flag_config_register;
        end
        else if (sel_status)
        begin
            next_rdata = {4'h0, event_status};
        end
        else if (sel_mask)
        begin
            next_rdata = {4'h0, event_mask};
        end
        else
        begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_read)
        begin
            reg_rdata <= next_rdata;
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

/* File: logic/ovf_pkg.sv */
// Constants and carrier types for the overrange flag block.
// Assumes one device clock domain and an 8-bit register port.
package ovf_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam int IDX_W = 10;
    localparam logic [IDX_W-1:0] IDX_FIRST_LEVEL_LIMIT = 10'h211;
    localparam logic [IDX_W-1:0] IDX_SECOND_LEVEL_LIMIT = 10'h212;
    localparam logic [IDX_W-1:0] IDX_FLAG_CONFIG = 10'h213;
    localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 10'h220;
    localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 10'h221;
    localparam int ADDR_W = 12;
    localparam logic [1:0] ADDR_LANE = 2'h0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_FIRST_LEVEL_LIMIT = 8'hf2;
    localparam logic [7:0] RST_SECOND_LEVEL_LIMIT = 8'hab;
    localparam logic [7:0] RST_FLAG_CONFIG = 8'h07;
    localparam logic [3:0] RST_EVENT_STATUS = 4'h0;
    localparam logic [3:0] RST_EVENT_MASK = 4'h0;

    // ****************************************************************
    // Field positions of the flag configuration register
    // ****************************************************************
    localparam int CFG_EXP_LSB = 0;
    localparam int CFG_EXP_W = 3;
    localparam int CFG_PIN_EN_BIT = 3;
    localparam int CFG_USED_W = 4;

    // ****************************************************************
    // Event status bit positions
    // ****************************************************************
    localparam int EV_A_ZERO = 0;
    localparam int EV_A_ONE = 1;
    localparam int EV_B_ZERO = 2;
    localparam int EV_B_ONE = 3;
    localparam int EV_W = 4;

    // ****************************************************************
    // Timing: monitoring period is PERIOD_BASE << exponent cycles
    // ****************************************************************
    localparam int PERIOD_W = 11;
    localparam logic [PERIOD_W-1:0] PERIOD_BASE = 11'h008;
    localparam logic [PERIOD_W-1:0] PERIOD_ONE = 11'h001;

    // ****************************************************************
    // Magnitude scale: limit of 256 stands for full-scale peak
    // ****************************************************************
    localparam int SAMPLE_W = 8;
    localparam int MAG_W = 9;
    localparam int LIMIT_W = 8;

    typedef struct packed {
        logic [SAMPLE_W-1:0] sample;
        logic [1:0] over;
    } ovf_sample_s;

    typedef struct packed {
        logic pin_enable;
        logic [CFG_EXP_W-1:0] exponent;
    } ovf_cfg_s;

endpackage

/* File: logic/ovf_stretch.sv */
// Pulse stretcher for the two flag pins of one channel.
// Assumes a period_end pulse from a shared monitoring period counter.
`timescale 1ns/100ps

module ovf_stretch #(
    parameter int FLAGS = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic period_end,
    input wire logic pin_enable,
    input wire logic [FLAGS-1:0] hit,
    output logic [FLAGS-1:0] flag
);

    // ****************************************************************
    // Per flag: gather hits of this period, hold them one more period
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < FLAGS; i = i + 1)
        begin : g_flag
            logic seen;
            logic held;
            logic next_seen;

            assign next_seen = seen | hit[i];

            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    seen <= 1'b0;
                    held <= 1'b0;
                end
                else if (period_end)
                begin
                    seen <= 1'b0;
                    held <= next_seen;
                end
                else
                begin
                    seen <= next_seen;
                end
            end

            always_ff @(posedge clk or posedge reset)
            begin
                if (reset)
                begin
                    flag[i] <= 1'b0;
                end
                else
                begin
                    flag[i] <= pin_enable & (next_seen | held);
                end
            end
        end
    endgenerate

endmodule

/* File: dv/ovf_flags_assertions.sv */
// Port-level checker for the overrange flag block.
// Assumes the byte addresses of the register port; bound into ovf_flags.
`timescale 1ns/100ps

module ovf_flags_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ovf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic [ovf_pkg::SAMPLE_W-1:0] chan_a_sample,
    input wire logic [ovf_pkg::SAMPLE_W-1:0] chan_b_sample,
    input wire ovf_pkg::ovf_sample_s chan_a_data_out,
    input wire ovf_pkg::ovf_sample_s chan_b_data_out,
    input wire logic chan_a_flag_zero,
    input wire logic chan_a_flag_one,
    input wire logic chan_b_flag_zero,
    input wire logic chan_b_flag_one
);
    function automatic logic [8:0] mag(input logic [7:0] s);
        return s[7] ? {8'(-s), 1'b0} : {s, 1'b0};
    endfunction

    logic [8:0] lim0;
    logic [8:0] lim1;
    logic [7:0] cfg_q;
    logic [11:0] hi_n;
    wire [8:0] mag_a = mag(chan_a_sample);
    wire [8:0] mag_b = mag(chan_b_sample);
    wire pin_en = cfg_q[3];
    wire [3:0] pins = {chan_b_flag_one, chan_b_flag_zero, chan_a_flag_one, chan_a_flag_zero};
    wire [3:0] ovr = {chan_b_data_out.over, chan_a_data_out.over};

    // Shadow of limits and configuration
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            lim0 <= 9'h0f2;
            lim1 <= 9'h0ab;
            cfg_q <= 8'h07;
        end
        else if (reg_write)
        begin
            case (reg_addr)
                12'h844: lim0 <= {1'b0, reg_wdata};
                12'h848: lim1 <= {1'b0, reg_wdata};
                12'h84c: cfg_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // High run of the first channel A pin
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            hi_n <= 12'h000;
        else
            hi_n <= chan_a_flag_zero ? hi_n + 12'h001 : 12'h000;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence pins_off;
        !pin_en;
    endsequence

    sequence pulse_end;
        $fell(chan_a_flag_zero) && pin_en;
    endsequence

    first_hit_a: assert property (
        !$past(reset) |-> ovr[0] == ($past(mag_a) >= $past(lim0))) else $error("first hit");
    second_hit_a: assert property (
        !$past(reset) |-> ovr[1] == ($past(mag_a) >= $past(lim1))) else $error("second hit");
    full_scale_a: assert property (
        !$past(reset) && $past(chan_a_sample) == 8'h80 |-> ovr[1:0] == 2'h3) else $error("full scale");
    chan_b_hit_a: assert property (
        !$past(reset) |-> ovr[3:2] == {$past(mag_b) >= $past(lim1), $past(mag_b) >= $past(lim0)})
        else $error("B hit");
    data_copy_a: assert property (
        !$past(reset) |-> chan_a_data_out.sample == $past(chan_a_sample)
            && chan_b_data_out.sample == $past(chan_b_sample)) else $error("sample copy");
    pins_gated_a: assert property (
        pins_off |=> pins == 4'h0) else $error("pin while off");
    pulse_min_a: assert property (
        pulse_end |-> hi_n >= (12'h008 << cfg_q[2:0])) else $error("short pulse");
    pin_follows_a: assert property (
        $past(pin_en) |-> (pins & ovr) == ovr) else $error("missed hit");
endmodule

bind ovf_flags ovf_flags_assertions chk_u (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .chan_a_sample(chan_a_sample), .chan_b_sample(chan_b_sample),
    .chan_a_data_out(chan_a_data_out), .chan_b_data_out(chan_b_data_out),
    .chan_a_flag_zero(chan_a_flag_zero), .chan_a_flag_one(chan_a_flag_one),
    .chan_b_flag_zero(chan_b_flag_zero), .chan_b_flag_one(chan_b_flag_one)
);

/* File: dv/ovf_pin_watch.sv */
// External logic watching the four flag pins.
// Assumes pins in order A zero, A one, B zero, B one, synchronous to clk.
`timescale 1ns/100ps

module ovf_pin_watch (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] pins,
    output logic [3:0][11:0] last_len,
    output logic [3:0][7:0] rises
);
    logic [3:0][11:0] run;
    logic [3:0] prev;

    // Length of each finished pulse and count of pulses
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            run <= '0;
            prev <= '0;
            last_len <= '0;
            rises <= '0;
        end
        else
        begin
            prev <= pins;
            for (int i = 0; i < 4; i++)
            begin
                run[i] <= pins[i] ? run[i] + 12'h001 : 12'h000;
                if (prev[i] && !pins[i])
                    last_len[i] <= run[i];
                if (pins[i] && !prev[i])
                    rises[i] <= rises[i] + 8'h01;
            end
        end
    end
endmodule

/* File: dv/ovf_flags_bench.sv */
// Self-checking bench for the overrange flag block.
// Assumes package, checker and pin watcher compiled first; link stays off.
`timescale 1ns/100ps

`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); \
        end \
    end

module ovf_flags_bench;
    logic clk;
    logic reset;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_rdata;
    logic [7:0] chan_a_sample;
    logic [7:0] chan_b_sample;
    logic serial_link_enable;
    logic irq;
    ovf_pkg::ovf_sample_s chan_a_data_out;
    ovf_pkg::ovf_sample_s chan_b_data_out;
    wire [3:0] pins;
    logic [3:0][11:0] wt_len;
    logic [3:0][7:0] wt_rise;
    int n_fail = 0;
    int n_compared = 0;
    // Limit one, limit two, sample, expected hit bits
    logic [31:0] tbl [8] = '{32'hf2ab7903, 32'hf2ab7802, 32'hf2ab5602, 32'hf2ab5500,
        32'hf2ab8703, 32'hffff8003, 32'hffff7f00, 32'h1020f801};

    ovf_flags dut_u (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .chan_a_sample(chan_a_sample), .chan_b_sample(chan_b_sample),
        .serial_link_enable(serial_link_enable), .chan_a_data_out(chan_a_data_out),
        .chan_b_data_out(chan_b_data_out), .chan_a_flag_zero(pins[0]), .chan_a_flag_one(pins[1]),
        .chan_b_flag_zero(pins[2]), .chan_b_flag_one(pins[3]), .irq(irq)
    );

    ovf_pin_watch watch_u (.clk(clk), .reset(reset), .pins(pins), .last_len(wt_len), .rises(wt_rise));

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    task automatic smp(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        chan_a_sample <= a;
        chan_b_sample <= b;
        @(posedge clk);
        chan_a_sample <= 8'h00;
        chan_b_sample <= 8'h00;
        #1;
    endtask

    task automatic tally_and_finish();
        $display("Compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        reset = 1'b1;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        chan_a_sample = 8'h00;
        chan_b_sample = 8'h00;
        serial_link_enable = 1'b0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        rd(12'h844, 8'hf2);
        rd(12'h848, 8'hab);
        rd(12'h84c, 8'h07);
        wr(12'h845, 8'h00);
        rd(12'h844, 8'hf2);
        rd(12'h845, 8'h00);
        foreach (tbl[i])
        begin
            wr(12'h844, tbl[i][31:24]);
            wr(12'h848, tbl[i][23:16]);
            smp(tbl[i][15:8], 8'h00);
            `CHK(chan_a_data_out, {tbl[i][15:8], tbl[i][1:0]})
            `CHK(chan_b_data_out, 10'h000)
            smp(8'h00, tbl[i][15:8]);
            `CHK(chan_b_data_out, {tbl[i][15:8], tbl[i][1:0]})
        end
        wr(12'h84c, 8'h00);
        repeat (20) @(posedge clk);
        for (int e = 0; e < 3; e++)
        begin
            wr(12'h84c, 8'h08 | 8'(e));
            smp(8'h80, 8'h0c);
            repeat (24 << e) @(posedge clk);
            #1;
            for (int p = 0; p < 3; p++)
                `CHK(wt_len[p] >= (12'h008 << e) && wt_len[p] <= (12'h010 << e) + 12'h001, 1'b1)
        end
        `CHK(wt_rise, 32'h00030303)
        wr(12'h84c, 8'h08);
        @(posedge clk);
        chan_a_sample <= 8'h80;
        repeat (4) @(posedge clk);
        #1;
        `CHK(pins, 4'h3)
        wr(12'h84c, 8'h00);
        // Pins drop one cycle after the disabling write
        @(posedge clk);
        #1;
        `CHK(pins, 4'h0)
        `CHK(chan_a_data_out.over, 2'h3)
        @(posedge clk);
        chan_a_sample <= 8'h00;
        rd(12'h880, 8'h0f);
        `CHK(irq, 1'b0)
        wr(12'h884, 8'h01);
        `CHK(irq, 1'b1)
        wr(12'h880, 8'h0f);
        `CHK(irq, 1'b0)
        rd(12'h880, 8'h00);
        smp(8'h00, 8'h7f);
        `CHK(irq, 1'b0)
        rd(12'h880, 8'h0c);
        wr(12'h884, 8'h0c);
        `CHK(irq, 1'b1)
        rd(12'h884, 8'h0c);
        tally_and_finish();
    end
endmodule
